// ===== hdl/rrse_exec.sv
// execution of return, rotate through carry and sleep
`timescale 1ns/1ps
`include "rrse_cfg.svh"
module rrse_exec (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // instruction fetch and phase
    input wire logic [13:0] instr_word,
    input wire logic [1:0] phase,
    // wake request from the wake-up logic
    input wire logic wake_req,
    // file register read port
    output logic [6:0] file_addr,
    input wire logic [7:0] file_rdata,
    // status and stack top inputs
    input wire logic carry_flag,
    input wire logic [12:0] stack_top_entry,
    // results
    output logic [7:0] result_data_ff,
    output logic file_we_ff,
    output logic w_we_ff,
    output logic carry_we_ff,
    output logic carry_new_ff,
    // program counter and stack
    output logic stack_pop_ff,
    output logic pc_load_ff,
    output logic [12:0] pc_value_ff,
    // power management
    output logic powerdown_status_flag_ff,
    output logic timeout_status_flag_ff,
    output logic watchdog_clear_ff,
    output logic [7:0] watchdog_counter_ff,
    output logic osc_stop_ff,
    output logic busy
);
    ////////////////////////////////////////////////////////////////////
    rrse_pkg::rrse_state_type state_ff;
    rrse_pkg::rrse_state_type nxt_state;
    logic [13:0] instr_ff;
    logic [7:0] operand_ff;
    logic is_ret;
    logic is_sleep;
    logic is_rot;
    logic rot_left;
    logic dest_file;
    logic ph_dec;
    logic ph_read;
    logic ph_write;
    rrse_rot_if rot ();

    assign ph_dec = (phase == `RRSE_PH_DECODE);
    assign ph_read = (phase == `RRSE_PH_READ);
    assign ph_write = (phase == `RRSE_PH_WRITE);
    // decode from the word latched in phase one
    assign is_ret = (instr_ff == `RRSE_OP_RETURN);
    assign is_sleep = (instr_ff == `RRSE_OP_SLEEP);
    assign rot_left =
        (instr_ff[`RRSE_OPC_HI:`RRSE_OPC_LO] == `RRSE_OP_ROT_LEFT);
    assign is_rot = rot_left
        || (instr_ff[`RRSE_OPC_HI:`RRSE_OPC_LO] == `RRSE_OP_ROT_RIGHT);
    assign dest_file = instr_ff[`RRSE_DEST_BIT];
    assign file_addr = instr_ff[`RRSE_ADDR_HI:0];
    assign busy = (state_ff != rrse_pkg::RRSE_EXEC);

    assign rot.data_in = operand_ff;
    assign rot.carry_in = carry_flag;
    assign rot.left = rot_left;
    rrse_rotator u_rot (
        .rot(rot)
    );

    ////////////////////////////////////////////////////////////////////
    // latch instruction in decode phase while in RRSE_EXEC, else load a zero word
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            instr_ff <= 14'h0000;
        else if (ph_dec && state_ff == rrse_pkg::RRSE_EXEC)
            instr_ff <= instr_word;
        else if (ph_dec)
            instr_ff <= 14'h0000;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            operand_ff <= 8'h00;
        else if (ph_read && is_rot)
            operand_ff <= file_rdata;
    end

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            rrse_pkg::RRSE_EXEC:
            begin
                if (ph_write && is_sleep)
                    nxt_state = rrse_pkg::RRSE_ASLEEP;
                else if (ph_write && is_ret)
                    nxt_state = rrse_pkg::RRSE_RET_NOP;
            end
            rrse_pkg::RRSE_RET_NOP:
            begin
                if (ph_write)
                    nxt_state = rrse_pkg::RRSE_EXEC;
            end
            rrse_pkg::RRSE_ASLEEP:
            begin
                if (wake_req)
                    nxt_state = rrse_pkg::RRSE_EXEC;
            end
            default:
                nxt_state = rrse_pkg::RRSE_EXEC;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            state_ff <= rrse_pkg::RRSE_EXEC;
        else
            state_ff <= nxt_state;
    end

    ////////////////////////////////////////////////////////////////////
    // status besides carry is never touched here
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            result_data_ff <= 8'h00;
            file_we_ff <= 1'b0;
            w_we_ff <= 1'b0;
            carry_we_ff <= 1'b0;
            carry_new_ff <= 1'b0;
        end
        else
        begin
            file_we_ff <= 1'b0;
            w_we_ff <= 1'b0;
            carry_we_ff <= 1'b0;
            if (ph_write && is_rot && state_ff == rrse_pkg::RRSE_EXEC)
            begin
                result_data_ff <= rot.result;
                carry_new_ff <= rot.carry_out;
                carry_we_ff <= 1'b1;
                file_we_ff <= dest_file;
                w_we_ff <= ~dest_file;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            stack_pop_ff <= 1'b0;
            pc_load_ff <= 1'b0;
            pc_value_ff <= 13'h0000;
        end
        else
        begin
            stack_pop_ff <= 1'b0;
            pc_load_ff <= 1'b0;
            if (ph_write && is_ret && state_ff == rrse_pkg::RRSE_EXEC)
            begin
                stack_pop_ff <= 1'b1;
                pc_load_ff <= 1'b1;
                pc_value_ff <= stack_top_entry;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flags are active low; reset values here suit a cold start
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            powerdown_status_flag_ff <= 1'b1;
            timeout_status_flag_ff <= 1'b1;
            watchdog_clear_ff <= 1'b0;
            watchdog_counter_ff <= `RRSE_WATCHDOG_CLEAR;
            osc_stop_ff <= 1'b0;
        end
        else
        begin
            watchdog_clear_ff <= 1'b0;
            if (ph_write && is_sleep && state_ff == rrse_pkg::RRSE_EXEC)
            begin
                powerdown_status_flag_ff <= 1'b0;
                timeout_status_flag_ff <= 1'b1;
                watchdog_counter_ff <= `RRSE_WATCHDOG_CLEAR;
                watchdog_clear_ff <= 1'b1;
                osc_stop_ff <= 1'b1;
            end
            else if (state_ff == rrse_pkg::RRSE_ASLEEP && wake_req)
                osc_stop_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    sequence seq_ret_issue;
        ph_write && is_ret && state_ff == rrse_pkg::RRSE_EXEC;
    endsequence

    AST_RET_POP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        seq_ret_issue |=> stack_pop_ff && pc_load_ff)
        else $error("return did not pop");
    AST_RET_VAL: assert property (@(posedge ref_clk) disable iff (sys_rst)
        seq_ret_issue |=> pc_value_ff == $past(stack_top_entry))
        else $error("pc not loaded from stack top");
    AST_RET_TWO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        seq_ret_issue |=> busy [*4])
        else $error("return second cycle missing");
    AST_ROT_LEFT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ph_write && is_rot && rot_left && !busy |=>
        result_data_ff == {$past(operand_ff[6:0]), $past(carry_flag)}
        && carry_new_ff == $past(operand_ff[7]))
        else $error("left rotate wrong");
    AST_ROT_RIGHT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ph_write && is_rot && !rot_left && !busy |=>
        result_data_ff == {$past(carry_flag), $past(operand_ff[7:1])}
        && carry_new_ff == $past(operand_ff[0]))
        else $error("right rotate wrong");
    AST_ROT_DEST: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ph_write && is_rot && !busy |=>
        file_we_ff == $past(dest_file) && w_we_ff == !$past(dest_file))
        else $error("rotate destination wrong");
    AST_ROT_ONLY_P4: assert property (@(posedge ref_clk) disable iff (sys_rst)
        carry_we_ff |-> $past(phase) == `RRSE_PH_WRITE)
        else $error("rotate write outside phase four");
    AST_SLEEP_FLAGS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ph_write && is_sleep && !busy |=> !powerdown_status_flag_ff
        && timeout_status_flag_ff)
        else $error("sleep flags wrong");
    AST_SLEEP_WDT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ph_write && is_sleep && !busy |=> watchdog_clear_ff
        && watchdog_counter_ff == `RRSE_WATCHDOG_CLEAR)
        else $error("watchdog not cleared");
    AST_SLEEP_OSC: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ph_write && is_sleep && !busy |=> osc_stop_ff
        && state_ff == rrse_pkg::RRSE_ASLEEP)
        else $error("sleep not entered");
endmodule : rrse_exec

// ===== hdl/rrse_cfg.svh
// constants for the return, rotate and sleep execution block
`ifndef RRSE_CFG_SVH
`define RRSE_CFG_SVH
`define RRSE_OP_RETURN 14'h0008
`define RRSE_OP_SLEEP 14'h0063
`define RRSE_OP_ROT_LEFT 6'h0D
`define RRSE_OP_ROT_RIGHT 6'h0C
`define RRSE_OPC_HI 13
`define RRSE_OPC_LO 8
`define RRSE_DEST_BIT 7
`define RRSE_ADDR_HI 6
`define RRSE_PH_DECODE 2'h0
`define RRSE_PH_READ 2'h1
`define RRSE_PH_PROC 2'h2
`define RRSE_PH_WRITE 2'h3
`define RRSE_WATCHDOG_CLEAR 8'h00
`endif

// ===== hdl/rrse_pkg.sv
// types for the return, rotate and sleep execution block
package rrse_pkg;
    typedef enum logic [1:0] {
        RRSE_EXEC,
        RRSE_RET_NOP,
        RRSE_ASLEEP
    } rrse_state_type;
endpackage : rrse_pkg

// ===== hdl/rrse_rot_if.sv
// carrier between the executor and its rotator
`timescale 1ns/1ps
interface rrse_rot_if;
    logic [7:0] data_in;
    logic carry_in;
    logic left;
    logic [7:0] result;
    logic carry_out;
    modport ctrl (output data_in, output carry_in, output left,
        input result, input carry_out);
    modport alu (input data_in, input carry_in, input left,
        output result, output carry_out);
endinterface : rrse_rot_if

// ===== hdl/rrse_rotator.sv
// rotate through carry datapath
`timescale 1ns/1ps
module rrse_rotator (
    rrse_rot_if.alu rot
);
    always_comb
    begin
        if (rot.left)
        begin
            rot.result = {rot.data_in[6:0], rot.carry_in};
            rot.carry_out = rot.data_in[7];
        end
        else
        begin
            rot.result = {rot.carry_in, rot.data_in[7:1]};
            rot.carry_out = rot.data_in[0];
        end
    end
endmodule : rrse_rotator

// ===== tb/test_return_rotate_sleep_exec.sv
// self-checking bench for the return, rotate and sleep executor
`timescale 1ns/1ps
`define CHK(g, e) chk((g) === (e), 32'(g), 32'(e))
module test_return_rotate_sleep_exec;
logic ref_clk = 1'b0, sys_rst = 1'b1, wake_req = 1'b0, carry_flag = 1'b0;
logic [13:0] instr_word = 14'h0000;
logic [1:0] phase = 2'h0;
logic [7:0] file_rdata = 8'h00, result_data_ff, watchdog_counter_ff, res;
logic [12:0] stack_top_entry = 13'h0000, pc_value_ff;
logic [6:0] file_addr, seen_addr;
logic file_we_ff, w_we_ff, carry_we_ff, carry_new_ff, stack_pop_ff;
logic pc_load_ff, powerdown_status_flag_ff, timeout_status_flag_ff;
logic watchdog_clear_ff, osc_stop_ff, busy, cnew, op, d, c;
logic [9:0] fl, snap;
logic [3:0] prev_we;
logic [7:0] dat;
integer failures = 0, checks_done = 0, cycles = 0, i;
////////////////////////////////////////////////////////////////////////
rrse_exec i_rrse_exec (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .instr_word(instr_word), .phase(phase), .wake_req(wake_req),
    .file_addr(file_addr), .file_rdata(file_rdata),
    .carry_flag(carry_flag), .stack_top_entry(stack_top_entry),
    .result_data_ff(result_data_ff), .file_we_ff(file_we_ff),
    .w_we_ff(w_we_ff), .carry_we_ff(carry_we_ff),
    .carry_new_ff(carry_new_ff), .stack_pop_ff(stack_pop_ff),
    .pc_load_ff(pc_load_ff), .pc_value_ff(pc_value_ff),
    .powerdown_status_flag_ff(powerdown_status_flag_ff),
    .timeout_status_flag_ff(timeout_status_flag_ff),
    .watchdog_clear_ff(watchdog_clear_ff),
    .watchdog_counter_ff(watchdog_counter_ff),
    .osc_stop_ff(osc_stop_ff), .busy(busy));
// pulse and status bits gathered so one compare covers them all
assign fl = {file_we_ff, w_we_ff, carry_we_ff, stack_pop_ff, pc_load_ff,
    watchdog_clear_ff, osc_stop_ff, busy, powerdown_status_flag_ff,
    timeout_status_flag_ff};
always #20 ref_clk = ~ref_clk;
////////////////////////////////////////////////////////////////////////
task chk(input logic ok, input logic [31:0] g, input logic [31:0] e);
    begin
        checks_done++;
        if (!ok)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    end
endtask : chk
task results;
    begin
        $display("TB: checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
endtask : results
// one instruction cycle then one follow cycle carrying word nw;
// entered and left just after an edge with phase 0 driven
task run(input logic [13:0] w, input logic [13:0] nw);
    integer k;
    begin
        instr_word = w;
        for (k = 0; k < 8; k++)
        begin
            @(posedge ref_clk);
            #1;
            // nothing may be written or stopped before phase four
            if (k == 2)
                prev_we = {carry_we_ff, stack_pop_ff, osc_stop_ff, busy};
            if (k == 1)
                seen_addr = file_addr;
            // pulses launched at the phase four edge stand until the next
            if (k == 3)
            begin
                snap = fl;
                res = result_data_ff;
                cnew = carry_new_ff;
            end
            instr_word = nw;
            phase = phase + 2'h1;
        end
    end
endtask : run
////////////////////////////////////////////////////////////////////////
// a hang is cut short well beyond the expected run length
always @(posedge ref_clk)
begin
    cycles++;
    if (cycles == 1000)
    begin
        failures++;
        results();
    end
end
initial
begin
    repeat (3) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    `CHK(fl, 10'h003);
    `CHK(watchdog_counter_ff, 8'h00);
    for (i = 0; i < 8; i++)
    begin
        op = i[2];
        d = i[1];
        c = i[0];
        dat = 8'hE6 ^ {i[2:0], 5'h00};
        carry_flag = c;
        file_rdata = dat;
        run({5'b00110, op, d, {7{c}}}, 14'h0000);
        `CHK(seen_addr, {7{c}});
        if (op)
        begin
            `CHK(res, {dat[6:0], c});
            `CHK(cnew, dat[7]);
        end
        else
        begin
            `CHK(res, {c, dat[7:1]});
            `CHK(cnew, dat[0]);
        end
        `CHK(snap, {d, ~d, 8'h83});
        `CHK(prev_we, 4'h0);
    end
    $display("TB: rotate tests done");
    stack_top_entry = 13'h1A5C;
    run(14'h0008, 14'h0D80);
    `CHK(snap, 10'h067);
    `CHK(pc_value_ff, 13'h1A5C);
    // the rotate word offered in the second cycle must be ignored
    `CHK({file_we_ff, w_we_ff, carry_we_ff, busy}, 4'h0);
    run(14'h0000, 14'h0000);
    `CHK(prev_we, 4'h0);
    $display("TB: return test done");
    run(14'h0063, 14'h0000);
    `CHK(snap, 10'h01D);
    `CHK(prev_we, 4'h0);
    `CHK(watchdog_counter_ff, 8'h00);
    `CHK(osc_stop_ff, 1'b1);
    wake_req = 1'b1;
    run(14'h0000, 14'h0000);
    wake_req = 1'b0;
    `CHK(snap, 10'h001);
    $display("TB: sleep test done");
    results();
end
endmodule : test_return_rotate_sleep_exec
